//--- inc/boot_loader_defines.svh
// Purpose: Offsets, field positions, limits and codes of the boot loader
// Assumes: Byte offsets on a 32-bit APB, word-addressed boot image
// Notes: Definitions only
`ifndef BOOT_LOADER_DEFINES_SVH
`define BOOT_LOADER_DEFINES_SVH
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_TBL 8'h04
`define REG_STAT 8'h08
`define REG_EXEC 8'h0c
`define REG_PCNT 8'h10
`define REG_SECT 8'h14
`define ROM_LO 8'h40
`define ROM_HI 8'h4c
// Control bits
`define CTRL_START 0
`define CTRL_JTAG 1
`define CTRL_INPLACE 2
// Partition header byte offsets, word index is offset / 4
`define HDR_LEN 8'h00
`define HDR_DLEN 8'h04
`define HDR_TOT 8'h08
`define HDR_LOAD 8'h0c
`define HDR_EXEC 8'h10
`define HDR_OFF 8'h14
`define HDR_ATTR 8'h18
`define HDR_SECT 8'h1c
`define HDR_CSUM 8'h3c
`define HDR_WORDS 16
`define ATTR_FAB 5
`define ATTR_CPU 4
// On-chip RAM sizing
`define RAM_BASE 32'h0000_0000
`define LDR_MAX_KB 192
`define RAM_KB 256
`define RSV_KB 64
`define LDR_MAX_WORDS (`LDR_MAX_KB * 1024 / 4)
// Error codes
`define ERR_NONE 3'h0
`define ERR_SRC 3'h1
`define ERR_CSUM 3'h2
`define ERR_SIZE 3'h3
`define ERR_NOLDR 3'h4
`endif

//--- inc/boot_loader_pkg.sv
// Purpose: Types shared by the boot partition loader
// Assumes: Constants live in boot_loader_defines.svh
// Notes: Whole loader state is one packed struct
package boot_loader_pkg;
    typedef enum logic [2:0] {
        S_IDLE, S_HDR, S_CHK, S_DATA, S_PUSH, S_NEXT, S_JUMP, S_END
    } state_e;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } mem_wr_s;
    typedef struct packed {
        state_e st;
        logic cap;
        logic secure;
        logic stage0;
        logic ram_full;
        logic use_jtag;
        logic inplace;
        logic fab;
        logic have_app;
        logic zero;
        logic done;
        logic mmu_off;
        logic jump;
        logic [2:0] err;
        logic [3:0] widx;
        logic [15:0][31:0] hdr;
        logic [31:0] sum;
        logic [31:0] tbl;
        logic [31:0] hptr;
        logic [31:0] raddr;
        logic [31:0] waddr;
        logic [31:0] left;
        logic [31:0] word;
        logic [31:0] exec;
        logic [7:0] pcnt;
    } ldr_s;
endpackage

//--- verilog/boot_partition_loader.sv
// Purpose: Boot loader walking partition headers of a boot image
// Assumes: Image port answers one word per ack, same-cycle data
// Notes: APB answers in the access cycle, pready always high
`timescale 1ns/10ps
`include "boot_loader_defines.svh"

// Contract
// - Secure boot uses static memory only, JTAG disabled; non-secure allows both.
// - Stage-zero phase never configures the fabric.
// - Stage-zero code storage is read-only; writes change nothing.
// - Stage zero copies the loader image into on-chip RAM before handing over, unless the loader executes in place.
// - Loader at most 192 KB; top 64 KB reserved until loader starts.
// - Loader runs from on-chip RAM or executes in place, per setting.
// - Stage zero never enables external DDR or snoop control unit.
// - One header per partition, loader included, walked in order.
// - An all-zero header apart from checksum ends the walk.
// - Word 0x00 is data length in words; 0x04 decrypted length.
// - Word 0x08 is total partition space in the image.
// - Load and execution addresses ignored for fabric partitions.
// - Word 0x14 is data start in words from image start.
// - Attribute bit 5 marks fabric bitstream, bit 4 processor code.
// - Word 0x1C counts data sections of memory-loaded partitions.
// - Word 0x3C is inverse of sum of earlier words; verified.
// - Loader searches the table for bitstream and application partitions.
// - Loader programs fabric, copies application, then transfers execution.
// - Memory management unit is switched off before the jump.
module boot_partition_loader (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Straps
    input wire logic secure_strap,
    // Boot image read port, word addressed
    output logic img_rd_req,
    output logic [31:0] img_rd_addr,
    input wire logic img_rd_ack,
    input wire logic [31:0] img_rd_data,
    // Fabric bitstream stream
    output logic fab_valid,
    output logic [31:0] fab_data,
    input wire logic fab_ready,
    // Memory copy port
    output logic mem_wr_valid,
    output boot_loader_pkg::mem_wr_s mem_wr,
    input wire logic mem_wr_ready,
    // System controls
    output logic jtag_en,
    output logic ddr_snoop_en,
    output logic ram_full,
    output logic mmu_off,
    output logic jump,
    output logic [31:0] exec_addr,
    output logic boot_err
);

    boot_loader_pkg::ldr_s s_q;
    boot_loader_pkg::ldr_s s_d;
    logic acc;
    logic wr;
    logic rom_hit;
    logic ctrl_start;
    logic [31:0] nsum;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    // Word index of a header byte offset
    function automatic logic [3:0] hw(input logic [7:0] off);
        hw = off[5:2];
    endfunction

    // Stage-zero code words; values are arbitrary
    function automatic logic [31:0] rom_word(input logic [1:0] i);
        case (i)
            2'h0: rom_word = 32'h5a5a_0001;
            2'h1: rom_word = 32'h5a5a_0002;
            2'h2: rom_word = 32'h5a5a_0003;
            default: rom_word = 32'h5a5a_0004;
        endcase
    endfunction

    // Word taken from the image this cycle
    function automatic logic taken(input boot_loader_pkg::ldr_s s, input logic ack);
        taken = ack && (s.st == boot_loader_pkg::S_HDR || s.st == boot_loader_pkg::S_DATA);
    endfunction

    // ----------------------------------------
    // APB access
    // ----------------------------------------
    // Zero wait states; accesses complete in the access cycle
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rom_hit = paddr >= `ROM_LO && paddr <= `ROM_HI;
    assign pready = 1'b1;
    assign ctrl_start = wr && paddr == `REG_CTRL && pwdata[`CTRL_START];

    // Read mux and error answer
    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (acc) begin
            case (paddr)
                `REG_CTRL: prdata = {29'h0, s_q.inplace, s_q.use_jtag, 1'b0};
                `REG_TBL: prdata = s_q.tbl;
                `REG_STAT: prdata = {22'h0, s_q.err, s_q.ram_full, s_q.stage0,
                    s_q.secure, s_q.mmu_off, s_q.done, s_q.err != `ERR_NONE,
                    s_q.st != boot_loader_pkg::S_IDLE && s_q.st != boot_loader_pkg::S_END};
                `REG_EXEC: prdata = s_q.exec;
                `REG_PCNT: prdata = {24'h0, s_q.pcnt};
                `REG_SECT: prdata = s_q.hdr[hw(`HDR_SECT)];
                default: begin
                    if (rom_hit && !pwrite) begin
                        prdata = rom_word(paddr[3:2]);
                    end else begin
                        pslverr = 1'b1;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Loader sequencing
    // ----------------------------------------
    assign nsum = s_q.sum + img_rd_data;

    // Next-state logic for the whole loader
    always_comb begin
        s_d = s_q;
        s_d.jump = 1'b0;
        if (!s_q.cap) begin
            s_d.cap = 1'b1;
            s_d.secure = secure_strap;
        end
        if (wr && paddr == `REG_TBL) begin
            s_d.tbl = pwdata;
        end
        if (wr && paddr == `REG_CTRL) begin
            s_d.use_jtag = pwdata[`CTRL_JTAG];
            s_d.inplace = pwdata[`CTRL_INPLACE];
        end
        case (s_q.st)
            boot_loader_pkg::S_IDLE, boot_loader_pkg::S_END: begin
                if (ctrl_start && s_q.cap) begin
                    s_d.done = 1'b0;
                    s_d.mmu_off = 1'b0;
                    s_d.have_app = 1'b0;
                    s_d.ram_full = 1'b0;
                    s_d.pcnt = 8'h00;
                    s_d.err = `ERR_NONE;
                    if (s_q.secure && pwdata[`CTRL_JTAG]) begin
                        s_d.err = `ERR_SRC;
                        s_d.st = boot_loader_pkg::S_END;
                    end else begin
                        s_d.stage0 = 1'b1;
                        s_d.hptr = s_q.tbl;
                        s_d.raddr = s_q.tbl;
                        s_d.widx = 4'h0;
                        s_d.sum = 32'h0000_0000;
                        s_d.zero = 1'b1;
                        s_d.st = boot_loader_pkg::S_HDR;
                    end
                end
            end
            boot_loader_pkg::S_HDR: begin
                if (taken(s_q, img_rd_ack)) begin
                    s_d.hdr[s_q.widx] = img_rd_data;
                    s_d.raddr = s_q.raddr + 32'h1;
                    s_d.widx = s_q.widx + 4'h1;
                    if (s_q.widx == hw(`HDR_CSUM)) begin
                        s_d.st = boot_loader_pkg::S_CHK;
                    end else begin
                        s_d.sum = nsum;
                        s_d.zero = s_q.zero && img_rd_data == 32'h0000_0000;
                    end
                end
            end
            boot_loader_pkg::S_CHK: begin
                s_d.raddr = s_q.hdr[hw(`HDR_OFF)];
                s_d.left = s_q.hdr[hw(`HDR_LEN)];
                s_d.fab = 1'b0;
                if (s_q.zero) begin
                    // Table end: an empty table has no loader at all
                    if (s_q.stage0) begin
                        s_d.err = `ERR_NOLDR;
                        s_d.st = boot_loader_pkg::S_END;
                    end else if (s_q.have_app) begin
                        s_d.mmu_off = 1'b1;
                        s_d.st = boot_loader_pkg::S_JUMP;
                    end else begin
                        s_d.done = 1'b1;
                        s_d.st = boot_loader_pkg::S_END;
                    end
                end else if (~s_q.sum != s_q.hdr[hw(`HDR_CSUM)]) begin
                    s_d.err = `ERR_CSUM;
                    s_d.st = boot_loader_pkg::S_END;
                end else begin
                    s_d.pcnt = s_q.pcnt + 8'h01;
                    s_d.st = boot_loader_pkg::S_DATA;
                    if (s_q.hdr[hw(`HDR_LEN)] > s_q.hdr[hw(`HDR_TOT)]) begin
                        // Longer data would run into the next partition
                        s_d.err = `ERR_SIZE;
                        s_d.st = boot_loader_pkg::S_END;
                    end else if (s_q.stage0) begin
                        if (s_q.hdr[hw(`HDR_LEN)] > `LDR_MAX_WORDS) begin
                            s_d.err = `ERR_SIZE;
                            s_d.st = boot_loader_pkg::S_END;
                        end else if (s_q.inplace) begin
                            // Runs from flash, nothing copied
                            s_d.exec = s_q.hdr[hw(`HDR_EXEC)];
                            s_d.st = boot_loader_pkg::S_NEXT;
                        end else begin
                            s_d.waddr = `RAM_BASE;
                            s_d.exec = `RAM_BASE;
                        end
                    end else if (s_q.hdr[hw(`HDR_ATTR)][`ATTR_FAB]) begin
                        s_d.fab = 1'b1;
                    end else if (s_q.hdr[hw(`HDR_ATTR)][`ATTR_CPU]) begin
                        s_d.waddr = s_q.hdr[hw(`HDR_LOAD)];
                        s_d.exec = s_q.hdr[hw(`HDR_EXEC)];
                        s_d.have_app = 1'b1;
                    end else begin
                        s_d.st = boot_loader_pkg::S_NEXT;
                    end
                    if (s_q.hdr[hw(`HDR_LEN)] == 32'h0000_0000) begin
                        s_d.st = boot_loader_pkg::S_NEXT;
                    end
                end
            end
            boot_loader_pkg::S_DATA: begin
                if (taken(s_q, img_rd_ack)) begin
                    s_d.word = img_rd_data;
                    s_d.raddr = s_q.raddr + 32'h1;
                    s_d.st = boot_loader_pkg::S_PUSH;
                end
            end
            boot_loader_pkg::S_PUSH: begin
                if (s_q.fab ? fab_ready : mem_wr_ready) begin
                    s_d.left = s_q.left - 32'h1;
                    s_d.waddr = s_q.waddr + 32'h4;
                    s_d.st = s_q.left == 32'h1 ? boot_loader_pkg::S_NEXT
                        : boot_loader_pkg::S_DATA;
                end
            end
            boot_loader_pkg::S_NEXT: begin
                // Leaving stage zero frees the reserved top of RAM
                if (s_q.stage0) begin
                    s_d.stage0 = 1'b0;
                    s_d.ram_full = 1'b1;
                end
                s_d.hptr = s_q.hptr + `HDR_WORDS;
                s_d.raddr = s_q.hptr + `HDR_WORDS;
                s_d.widx = 4'h0;
                s_d.sum = 32'h0000_0000;
                s_d.zero = 1'b1;
                s_d.st = boot_loader_pkg::S_HDR;
            end
            boot_loader_pkg::S_JUMP: begin
                s_d.jump = 1'b1;
                s_d.done = 1'b1;
                s_d.st = boot_loader_pkg::S_END;
            end
            default: s_d.st = boot_loader_pkg::S_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Handshake requests are decoded from state
    assign img_rd_req = s_q.st == boot_loader_pkg::S_HDR || s_q.st == boot_loader_pkg::S_DATA;
    assign img_rd_addr = s_q.raddr;
    assign fab_valid = s_q.st == boot_loader_pkg::S_PUSH && s_q.fab && !s_q.stage0;
    assign fab_data = s_q.word;
    assign mem_wr_valid = s_q.st == boot_loader_pkg::S_PUSH && !s_q.fab;
    assign mem_wr.addr = s_q.waddr;
    assign mem_wr.data = s_q.word;
    assign jtag_en = s_q.cap && !s_q.secure;
    assign ddr_snoop_en = 1'b0;
    assign ram_full = s_q.ram_full;
    assign mmu_off = s_q.mmu_off;
    assign jump = s_q.jump;
    assign exec_addr = s_q.exec;
    assign boot_err = s_q.err != `ERR_NONE;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence hdr_last;
        s_q.st == boot_loader_pkg::S_HDR && img_rd_ack && s_q.widx == 4'hf;
    endsequence
    sequence chk_bad;
        s_q.st == boot_loader_pkg::S_CHK && !s_q.zero && ~s_q.sum != s_q.hdr[15];
    endsequence
    // Walk end with an application, and an oversized loader header
    sequence term_app;
        s_q.st == boot_loader_pkg::S_CHK && s_q.zero && !s_q.stage0 && s_q.have_app;
    endsequence
    sequence ldr_big;
        s_q.st == boot_loader_pkg::S_CHK && s_q.stage0 && !s_q.zero
            && ~s_q.sum == s_q.hdr[15] && s_q.hdr[0] > `LDR_MAX_WORDS;
    endsequence

    chk_jtag_secure: assert property (s_q.secure |-> !jtag_en)
        else $error("jtag enabled in secure mode");
    chk_fab_stage0: assert property (s_q.stage0 |-> !fab_valid)
        else $error("fabric fed in stage zero");
    chk_rom_write: assert property (wr && rom_hit |-> pslverr)
        else $error("rom write not refused");
    chk_rom_read: assert property (acc && !pwrite && rom_hit |-> !pslverr)
        else $error("rom read refused");
    chk_ldr_bound: assert property (s_q.stage0 && mem_wr_valid |->
        mem_wr.addr < `RAM_BASE + `LDR_MAX_KB * 1024)
        else $error("loader copy beyond limit");
    chk_hdr_walk: assert property (hdr_last |=> s_q.st == boot_loader_pkg::S_CHK)
        else $error("header read not checked");
    chk_term_stop: assert property (s_q.st == boot_loader_pkg::S_CHK && s_q.zero
        |=> s_q.st != boot_loader_pkg::S_DATA [*2])
        else $error("walk continued past end");
    chk_csum_err: assert property (chk_bad |=> boot_err && s_q.st == boot_loader_pkg::S_END
        ##1 !fab_valid && !mem_wr_valid)
        else $error("bad checksum not flagged");
    chk_jump_mmu: assert property ($rose(jump) |-> mmu_off && $past(mmu_off))
        else $error("jump with mmu on");
    chk_one_port: assert property (fab_valid |-> !mem_wr_valid)
        else $error("fabric data sent to memory");

    // Handshakes stand until taken; a dropped word would corrupt the copy
    chk_rd_hold: assert property (img_rd_req && !img_rd_ack |=>
        img_rd_req && $stable(img_rd_addr))
        else $error("image read dropped before ack");
    chk_fab_hold: assert property (fab_valid && !fab_ready |=>
        fab_valid && $stable(fab_data))
        else $error("fabric word dropped");
    chk_mem_hold: assert property (mem_wr_valid && !mem_wr_ready |=>
        mem_wr_valid && $stable(mem_wr))
        else $error("memory word dropped");

    // Release order around the loader phase and the end of the walk
    chk_ram_hold: assert property (s_q.stage0 |-> !ram_full)
        else $error("reserved ram released in stage zero");
    chk_fab_late: assert property (fab_valid |-> ram_full)
        else $error("fabric fed before loader phase ended");
    chk_size_stop: assert property (ldr_big |=> boot_err)
        else $error("oversized loader accepted");
    chk_term_jump: assert property (term_app |=> mmu_off ##1 jump)
        else $error("walk end did not jump");
    chk_jump_pulse: assert property (jump |=> !jump)
        else $error("jump longer than one cycle");
    chk_src_refuse: assert property (ctrl_start && s_q.cap && s_q.secure
        && pwdata[`CTRL_JTAG]
        && (s_q.st == boot_loader_pkg::S_IDLE || s_q.st == boot_loader_pkg::S_END)
        |=> s_q.err == `ERR_SRC)
        else $error("jtag boot taken in secure mode");

endmodule

//--- tb/image_model.sv
// Purpose: Boot image store with fabric and memory sinks
// Assumes: Word-addressed image, one word per acknowledge
// Notes: Answers stall on alternate cycles, each ready stalls two cycles in four
`timescale 1ns/10ps
module image_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Image read port
    input wire logic img_rd_req,
    input wire logic [31:0] img_rd_addr,
    output logic img_rd_ack,
    output logic [31:0] img_rd_data,
    // Sinks
    output logic fab_ready,
    output logic mem_wr_ready
);
    logic [31:0] mem [0:255];
    logic [31:0] last_q;
    logic [1:0] cnt_q;

    // ----------------------------------------------------------------
    // Slow answers
    // ----------------------------------------------------------------
    // Stall pattern, so no side is ever answered at once every time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 2'h0;
            last_q <= 32'h0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            if (img_rd_ack) begin
                last_q <= img_rd_data;
            end
        end
    end
    assign img_rd_ack = img_rd_req & cnt_q[0];
    // Outside an answer the bus shows the inverse of the last word
    assign img_rd_data = img_rd_ack ? mem[img_rd_addr[7:0]] : ~last_q;
    assign fab_ready = cnt_q[1];
    assign mem_wr_ready = ~cnt_q[1];
endmodule

//--- tb/testbench.sv
// Purpose: Self-checking bench of the boot partition loader
// Assumes: Header table at image word 0, data from word 64
// Notes: Scenarios are tasks; transfers are logged by monitors
`timescale 1ns/10ps
`include "boot_loader_defines.svh"
module testbench;
    logic pclk, presetn, psel, penable, pwrite, secure_strap, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, img_rd_addr, img_rd_data, fab_data, exec_addr, jaddr, v, v2;
    logic img_rd_req, img_rd_ack, fab_valid, fab_ready, mem_wr_valid, mem_wr_ready;
    logic jtag_en, ddr_snoop_en, ram_full, mmu_off, jump, boot_err, e;
    boot_loader_pkg::mem_wr_s mem_wr;
    int miscompares, checks_done, jumps, mmu_bad, fab_early;
    logic [31:0] fq[$], mq[$], aq[$];

    boot_partition_loader DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .secure_strap(secure_strap), .img_rd_req(img_rd_req),
        .img_rd_addr(img_rd_addr), .img_rd_ack(img_rd_ack), .img_rd_data(img_rd_data),
        .fab_valid(fab_valid), .fab_data(fab_data), .fab_ready(fab_ready),
        .mem_wr_valid(mem_wr_valid), .mem_wr(mem_wr), .mem_wr_ready(mem_wr_ready),
        .jtag_en(jtag_en), .ddr_snoop_en(ddr_snoop_en), .ram_full(ram_full),
        .mmu_off(mmu_off), .jump(jump), .exec_addr(exec_addr), .boot_err(boot_err));
    image_model img (.pclk(pclk), .presetn(presetn), .img_rd_req(img_rd_req),
        .img_rd_addr(img_rd_addr), .img_rd_ack(img_rd_ack), .img_rd_data(img_rd_data),
        .fab_ready(fab_ready), .mem_wr_ready(mem_wr_ready));

    // ----------------------------------------------------------------
    // Clock and transfer monitors
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Logs every accepted word; fabric traffic before release is flagged
    always @(posedge pclk) begin
        if (fab_valid === 1'b1 && fab_ready === 1'b1) begin
            fq.push_back(fab_data);
            if (ram_full !== 1'b1) fab_early++;
        end
        if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) begin
            mq.push_back(mem_wr.data);
            aq.push_back(mem_wr.addr);
        end
        if (jump === 1'b1) begin
            jumps++;
            jaddr = exec_addr;
            if (mmu_off !== 1'b1) mmu_bad++;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // APB master and helpers
    // ----------------------------------------------------------------
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                q = prdata;
                err = pslverr;
                break;
            end
            if (i == 49) begin
                miscompares++;
                results();
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset(input logic strap);
        secure_strap <= strap;
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        fq.delete();
        mq.delete();
        aq.delete();
        jumps = 0;
    endtask

    // Header of entry n, checksum is the inverse of the word sum
    task automatic hdr(input int n, input logic [31:0] len, ld, ex, off, attr);
        logic [31:0] s;
        for (int i = 0; i < 16; i++) img.mem[16 * n + i] = 32'h0;
        img.mem[16 * n + 0] = len;
        img.mem[16 * n + 1] = len;
        img.mem[16 * n + 2] = len;
        img.mem[16 * n + 3] = ld;
        img.mem[16 * n + 4] = ex;
        img.mem[16 * n + 5] = off;
        img.mem[16 * n + 6] = attr;
        img.mem[16 * n + 7] = {31'h0, attr[4]};
        s = 32'h0;
        for (int i = 0; i < 15; i++) s = s + img.mem[16 * n + i];
        img.mem[16 * n + 15] = ~s;
    endtask

    task automatic boot_run(input logic [31:0] ctrl);
        apb(1'b1, `REG_TBL, 32'h0, v, e);
        apb(1'b1, `REG_CTRL, ctrl, v, e);
        for (int i = 0; i < 3000; i++) begin
            @(posedge pclk);
            if (jumps > 0 || boot_err === 1'b1) break;
            if (i == 2999) begin
                miscompares++;
                results();
            end
        end
        repeat (4) @(posedge pclk);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_idle();
        chk(ddr_snoop_en, 1'b0);
        chk(jtag_en, 1'b1);
        chk(ram_full, 1'b0);
        apb(1'b0, `ROM_LO, 32'h0, v, e);
        apb(1'b1, `ROM_LO, ~v, v2, e);
        chk(e, 1'b1);
        apb(1'b0, `ROM_LO, 32'h0, v2, e);
        chk(v2, v);
        apb(1'b0, 8'h80, 32'h0, v2, e);
        chk(v2, 32'h0);
        chk(e, 1'b1);
    endtask

    // Loader, fabric, application, terminator; fabric addresses are junk
    task automatic t_boot();
        boot_run(32'h1);
        chk(fab_early, 0);
        chk(fq.size(), 3);
        for (int i = 0; i < 3; i++) chk(fq[i], 32'hd000_0042 + i);
        chk(mq.size(), 4);
        chk(mq[0], 32'hd000_0040);
        chk(mq[3], 32'hd000_0046);
        chk(aq[0], `RAM_BASE);
        chk(aq[2], 32'h0000_1000);
        chk(jumps, 1);
        chk(jaddr, 32'h0000_2000);
        chk(mmu_bad, 0);
        chk(ram_full, 1'b1);
        apb(1'b0, `REG_STAT, 32'h0, v, e);
        chk(v & 32'h4e, 32'h4c);
    endtask

    task automatic t_csum();
        img.mem[47] = img.mem[47] ^ 32'h1;
        do_reset(1'b0);
        boot_run(32'h1);
        chk(boot_err, 1'b1);
        chk(jumps, 0);
        chk(mq.size(), 2);
        apb(1'b0, `REG_STAT, 32'h0, v, e);
        chk(v[9:7], `ERR_CSUM);
        apb(1'b0, `REG_SECT, 32'h0, v, e);
        chk(v, 32'h1);
        img.mem[47] = img.mem[47] ^ 32'h1;
    endtask

    task automatic t_secure();
        do_reset(1'b1);
        chk(jtag_en, 1'b0);
        apb(1'b1, `REG_CTRL, 32'h3, v, e);
        repeat (4) @(posedge pclk);
        chk(boot_err, 1'b1);
        apb(1'b0, `REG_STAT, 32'h0, v, e);
        chk(v[9:7], `ERR_SRC);
        chk(fq.size() + mq.size(), 0);
        boot_run(32'h5);
        chk(boot_err, 1'b0);
        chk(jumps, 1);
        chk(mq.size(), 2);
        chk(aq[0], 32'h0000_1000);
    endtask

    initial begin
        miscompares = 0;
        checks_done = 0;
        mmu_bad = 0;
        fab_early = 0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        for (int i = 0; i < 256; i++) img.mem[i] = 32'hd000_0000 + i;
        hdr(0, 32'h2, 32'h0, 32'h0, 32'h40, 32'h10);
        hdr(1, 32'h3, 32'hdead_0000, 32'hdead_0004, 32'h42, 32'h20);
        hdr(2, 32'h2, 32'h0000_1000, 32'h0000_2000, 32'h45, 32'h10);
        hdr(3, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0);
        do_reset(1'b0);
        t_idle();
        t_boot();
        t_csum();
        t_secure();
        results();
    end
endmodule
